/* src/tfs_map.svh */
`ifndef TFS_MAP_SVH
`define TFS_MAP_SVH
// Clock rate and phase timing
`define TFS_CLOCK_MHZ 50
`define TFS_PHASE_NS 2000
`define TFS_HALF_NS 1000
`define TFS_HALF_CYCLES ((`TFS_HALF_NS * `TFS_CLOCK_MHZ) / 1000)
// Phase numbering
`define TFS_PHASE_COUNT 8
`define TFS_PHASE_FIRST 3'h0
`define TFS_PHASE_FOURTH 3'h3
`define TFS_PHASE_FIFTH 3'h4
`define TFS_PHASE_SIXTH 3'h5
`define TFS_PHASE_LAST 3'h7
// Counter widths and reset values
`define TFS_STEP_WIDTH 8
`define TFS_STEP_RESET 8'h00
`define TFS_INDEX_WIDTH 15
`define TFS_DIV_WIDTH 6
`endif

/* src/tfs_pkg.sv */
package tfs_pkg;
`include "tfs_map.svh"
   typedef enum logic {tfs_half_first, tfs_half_second} tfs_half_type;
   // Step counter micro-operation commands
   typedef struct packed {
      logic inc;
      logic dec;
   } tfs_step_cmd_type;
   // Phase-hold commands from micro-operations
   typedef struct packed {
      logic set;
      logic clear;
   } tfs_hold_cmd_type;
   // Timing outputs seen by micro-operation logic
   typedef struct packed {
      logic [2:0] timing_phase;
      logic first_pulse;
      logic second_pulse;
      logic first_level;
      logic second_level;
   } tfs_timing_type;
endpackage

/* src/tfs_pulse_timer.sv */
`timescale 1ns/10ps
`include "tfs_map.svh"
// Divides the clock into alternating half-phase slots of 1 us
module tfs_pulse_timer
   import tfs_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   output logic slot_tick
);
   typedef struct packed {
      logic [`TFS_DIV_WIDTH-1:0] count;
      logic tick;
   } tfs_div_state_type;
   localparam logic [`TFS_DIV_WIDTH-1:0] last_count = `TFS_DIV_WIDTH'(`TFS_HALF_CYCLES - 1);
   tfs_div_state_type state;
   tfs_div_state_type next_state;

   // Count one half-phase, then pulse
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (state.count == last_count) begin
         next_state.count = '0;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + `TFS_DIV_WIDTH'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign slot_tick = state.tick;
endmodule

/* src/tfs_step_counter.sv */
`timescale 1ns/10ps
`include "tfs_map.svh"
// Up/down step counter, shift count and auxiliary timer
module tfs_step_counter
   import tfs_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic apply,
   input wire logic clear,
   input wire tfs_step_cmd_type cmd,
   output logic [`TFS_STEP_WIDTH-1:0] count
);
   typedef struct packed {
      logic [`TFS_STEP_WIDTH-1:0] value;
   } tfs_step_state_type;
   tfs_step_state_type state;
   tfs_step_state_type next_state;

   // Clear wins over step; inc and dec together cancel
   always_comb begin
      next_state = state;
      if (apply) begin
         if (clear) begin
            next_state.value = `TFS_STEP_RESET;
         end else if (cmd.inc && !cmd.dec) begin
            next_state.value = state.value + `TFS_STEP_WIDTH'h01;
         end else if (cmd.dec && !cmd.inc) begin
            next_state.value = state.value - `TFS_STEP_WIDTH'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign count = state.value;
endmodule

/* src/tfs_sequencer.sv */
`timescale 1ns/10ps
`include "tfs_map.svh"
// Summary of operation
// - Machine cycle has eight timing phases
// - Phase 2 us, half pulses 1 us apart
// - First-half operations precede second-half operations
// - Every first-half pulse followed by second-half
// - Internal phase-hold flag may stretch phases
// - Hold set on second-half repeats next phase
// - Hold set on first-half repeats that phase
// - Hold cleared on second-half: one more repeat
// - Hold cleared on first-half: finish, then advance
// - Step counter increments or decrements by one
// - Step counter cleared in eighth phase
// - Step counter is shift-count control
// - Step counter times held phases
// - Empty phases still take their slot
// - Exit at fourth phase continues fifth
// - After sixth phase, next instruction begins
// - Same-pulse actions happen in parallel
// - Half levels alternate at 500 kHz each
// - Halt flag set stops advancing
// - Nonload flag set on non-read-in start
// - Repeat: sixth phase decrements index, no fetch
module tfs_sequencer
   import tfs_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire tfs_hold_cmd_type hold_cmd,
   input wire tfs_step_cmd_type step_cmd,
   input wire logic exit_at_fourth,
   input wire logic halt_set,
   input wire logic halt_clear,
   input wire logic start_operation,
   input wire logic start_is_read_in,
   input wire logic repeat_start,
   input wire logic repeat_stop,
   input wire logic [`TFS_INDEX_WIDTH-1:0] repeat_load_value,
   output tfs_timing_type timing,
   output logic phase_hold,
   output logic [`TFS_STEP_WIDTH-1:0] shift_count,
   output logic halted,
   output logic nonload_operation_flag,
   output logic repeat_active_flag,
   output logic [`TFS_INDEX_WIDTH-1:0] repeat_count_index,
   output logic new_instruction
);
   typedef struct packed {
      logic [2:0] phase;
      tfs_half_type half;
      logic hold;
      logic held_extra;
      logic halt;
      logic nonload;
      logic rep;
      logic [`TFS_INDEX_WIDTH-1:0] index;
      logic first_pulse;
      logic second_pulse;
      logic fetch;
   } tfs_seq_state_type;

   tfs_seq_state_type state;
   tfs_seq_state_type next_state;
   logic slot_tick;
   logic step_apply;
   logic step_clear;

   // Next phase with fourth-phase exit folded in
   function automatic logic [2:0] tfs_next_phase(input logic [2:0] ph, input logic exit4);
      if (exit4 && ph <= `TFS_PHASE_FOURTH) begin
         tfs_next_phase = `TFS_PHASE_FIFTH;
      end else begin
         tfs_next_phase = ph + 3'h1;
      end
   endfunction

   tfs_pulse_timer u_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .slot_tick(slot_tick)
   );

   // Step counter acts on each pulse while not halted, cleared in last phase
   assign step_apply = slot_tick && !state.halt;
   assign step_clear = (state.phase == `TFS_PHASE_LAST) && (state.half == tfs_half_second);

   tfs_step_counter u_step (
      .clock(clock),
      .sys_rst(sys_rst),
      .apply(step_apply),
      .clear(step_clear),
      .cmd(step_cmd),
      .count(shift_count)
   );

   // Sequencer next-state: all same-pulse actions evaluated together
   always_comb begin
      next_state = state;
      next_state.first_pulse = 1'b0;
      next_state.second_pulse = 1'b0;
      next_state.fetch = 1'b0;
      // Halt flag, set wins over clear
      if (halt_set) begin
         next_state.halt = 1'b1;
      end else if (halt_clear) begin
         next_state.halt = 1'b0;
      end
      if (start_operation && !start_is_read_in) begin
         next_state.nonload = 1'b1;
      end
      if (repeat_start) begin
         next_state.rep = 1'b1;
         next_state.index = repeat_load_value;
      end else if (repeat_stop) begin
         next_state.rep = 1'b0;
      end
      if (slot_tick && !state.halt) begin
         if (state.half == tfs_half_first) begin
            // First half ends: second half always follows
            next_state.half = tfs_half_second;
            next_state.second_pulse = 1'b1;
            if (hold_cmd.set) begin
               next_state.hold = 1'b1;
            end else if (hold_cmd.clear) begin
               next_state.hold = 1'b0;
            end
         end else begin
            // Second half ends: decide repeat or advance
            next_state.half = tfs_half_first;
            next_state.first_pulse = 1'b1;
            next_state.held_extra = 1'b0;
            if (hold_cmd.set) begin
               next_state.hold = 1'b1;
               if (!state.hold) begin
                  next_state.phase = tfs_next_phase(state.phase, exit_at_fourth);
               end
            end else if (hold_cmd.clear && state.hold) begin
               next_state.hold = 1'b0;
               next_state.held_extra = 1'b1;
            end else if (state.hold) begin
               next_state.phase = state.phase;
            end else if (state.held_extra) begin
               next_state.phase = tfs_next_phase(state.phase, exit_at_fourth);
            end else begin
               next_state.phase = tfs_next_phase(state.phase, exit_at_fourth);
            end
            // A repeat loaded on this boundary wins: no fetch, no decrement
            if (state.phase == `TFS_PHASE_SIXTH && !state.hold && !repeat_start) begin
               if (state.rep) begin
                  next_state.index = state.index - `TFS_INDEX_WIDTH'h0001;
               end else begin
                  next_state.fetch = 1'b1;
               end
            end
         end
      end
   end

   // Register the whole state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
         state.phase <= `TFS_PHASE_FIRST;
         state.half <= tfs_half_first;
      end else begin
         state <= next_state;
      end
   end

   // Timing outputs
   assign timing.timing_phase = state.phase;
   assign timing.first_pulse = state.first_pulse;
   assign timing.second_pulse = state.second_pulse;
   assign timing.first_level = (state.half == tfs_half_first);
   assign timing.second_level = (state.half == tfs_half_second);
   assign phase_hold = state.hold;
   assign halted = state.halt;
   assign nonload_operation_flag = state.nonload;
   assign repeat_active_flag = state.rep;
   assign repeat_count_index = state.index;
   assign new_instruction = state.fetch;
endmodule

/* sim/tfs_sequencer_checker.sv */
`timescale 1ns/10ps
module tfs_sequencer_checker
   import tfs_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic halt_set,
   input wire logic start_operation,
   input wire logic start_is_read_in,
   input wire tfs_timing_type timing,
   input wire logic [7:0] shift_count,
   input wire logic halted,
   input wire logic nonload_operation_flag,
   input wire logic repeat_active_flag,
   input wire logic new_instruction
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Second half follows 50 clocks on, no first pulse between
   sequence half_gap_s;
      !timing.first_pulse throughout (##49 timing.second_pulse);
   endsequence
   sequence phase_step_s;
      timing.timing_phase == 3'($past(timing.timing_phase) + 3'h1) || timing.timing_phase == 3'h4;
   endsequence
   // Pulse, level and phase relations
   first_level_a: assert property (timing.first_pulse |-> timing.first_level && !timing.second_level)
      else $error("first pulse outside first half");
   second_level_a: assert property (timing.second_pulse |-> timing.second_level && !timing.first_level)
      else $error("second pulse outside second half");
   half_gap_a: assert property (disable iff (sys_rst || halted) timing.first_pulse |=> half_gap_s)
      else $error("half spacing wrong");
   phase_seq_a: assert property ($changed(timing.timing_phase) |-> phase_step_s)
      else $error("phase order wrong");
   phase_pulse_a: assert property (!timing.first_pulse |-> $stable(timing.timing_phase))
      else $error("phase moved without first pulse");
   step_clear_a: assert property ($changed(timing.timing_phase) && timing.timing_phase == 3'h0 |-> shift_count == 8'h00)
      else $error("step counter not cleared");
   step_one_a: assert property ($changed(shift_count) && shift_count != 8'h00 |->
      shift_count == 8'($past(shift_count) + 8'h01) || shift_count == 8'($past(shift_count) - 8'h01))
      else $error("step counter jumped");
   halt_freeze_a: assert property (halted |=> !timing.first_pulse && !timing.second_pulse)
      else $error("pulse while halted");
   halt_take_a: assert property (halt_set |=> halted)
      else $error("halt not taken");
   nonload_set_a: assert property (start_operation && !start_is_read_in |=> nonload_operation_flag)
      else $error("nonload flag not set");
   repeat_fetch_a: assert property (repeat_active_flag |-> !new_instruction)
      else $error("new instruction during repeat");
endmodule
bind tfs_sequencer tfs_sequencer_checker checker_inst (
   .clock(clock),
   .sys_rst(sys_rst),
   .halt_set(halt_set),
   .start_operation(start_operation),
   .start_is_read_in(start_is_read_in),
   .timing(timing),
   .shift_count(shift_count),
   .halted(halted),
   .nonload_operation_flag(nonload_operation_flag),
   .repeat_active_flag(repeat_active_flag),
   .new_instruction(new_instruction)
);

/* sim/tb_tfs_sequencer.sv */
`timescale 1ns/10ps
module tb_tfs_sequencer;
   import tfs_pkg::*;
   logic clock = 0, sys_rst = 1, exit_at_fourth = 0, halt_set = 0, halt_clear = 0;
   logic start_operation = 0, start_is_read_in = 0, repeat_start = 0, repeat_stop = 0;
   logic [14:0] repeat_load_value = 15'h0005, repeat_count_index;
   tfs_hold_cmd_type hold_cmd = '0;
   tfs_step_cmd_type step_cmd = '0;
   tfs_timing_type timing;
   logic phase_hold, halted, nonload_operation_flag, repeat_active_flag, new_instruction;
   logic [7:0] shift_count;
   int errors = 0, num_checks = 0;
   tfs_sequencer DUT (
      .clock(clock),
      .sys_rst(sys_rst),
      .hold_cmd(hold_cmd),
      .step_cmd(step_cmd),
      .exit_at_fourth(exit_at_fourth),
      .halt_set(halt_set),
      .halt_clear(halt_clear),
      .start_operation(start_operation),
      .start_is_read_in(start_is_read_in),
      .repeat_start(repeat_start),
      .repeat_stop(repeat_stop),
      .repeat_load_value(repeat_load_value),
      .timing(timing),
      .phase_hold(phase_hold),
      .shift_count(shift_count),
      .halted(halted),
      .nonload_operation_flag(nonload_operation_flag),
      .repeat_active_flag(repeat_active_flag),
      .repeat_count_index(repeat_count_index),
      .new_instruction(new_instruction)
   );
   // Clock
   always #10 clock = ~clock;
   task summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [14:0] s, input logic [14:0] e, input string m);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Bounded wait for the next first-half pulse
   task nextp;
      int i;
      wt(1);
      for (i = 0; i < 300 && timing.first_pulse !== 1'b1; i++) wt(1);
      if (i == 300) begin
         errors++;
         summarize;
      end
   endtask
   task t_cycle;
      time t;
      chk(timing.timing_phase, 0, "reset phase");
      nextp;
      step_cmd.inc = 1;
      for (int k = 2; k <= 8; k++) begin
         t = $time;
         nextp;
         chk(timing.timing_phase, k % 8, "phase");
         chk(15'(($time - t) / 20), 100, "phase length");
         chk(shift_count, (k == 8) ? 0 : 2 * (k - 1), "step count");
      end
      step_cmd.inc = 0;
      $display("t_cycle done");
   endtask
   task t_exit_hold;
      int i;
      nextp;
      exit_at_fourth = 1;
      nextp;
      chk(timing.timing_phase, 4, "exit jump");
      exit_at_fourth = 0;
      // Hold raised in a first half: that phase repeats
      hold_cmd.set = 1;
      step_cmd.inc = 1;
      for (i = 0; i < 3; i++) begin
         nextp;
         chk(timing.timing_phase, 4, "held phase");
      end
      chk(phase_hold, 1, "hold flag");
      chk(shift_count, 6, "timer while held");
      step_cmd.inc = 0;
      hold_cmd.set = 0;
      hold_cmd.clear = 1;
      nextp;
      chk(timing.timing_phase, 5, "first-half release");
      chk(phase_hold, 0, "hold cleared");
      hold_cmd.clear = 0;
      // Hold raised in a second half: next phase repeats
      wt(50);
      hold_cmd.set = 1;
      nextp;
      chk(timing.timing_phase, 6, "second-half set");
      hold_cmd.set = 0;
      nextp;
      chk(timing.timing_phase, 6, "next phase held");
      wt(50);
      hold_cmd.clear = 1;
      nextp;
      chk(timing.timing_phase, 6, "extra repeat");
      hold_cmd.clear = 0;
      nextp;
      chk(timing.timing_phase, 7, "release advance");
      $display("t_exit_hold done");
   endtask
   task t_halt;
      logic [2:0] p;
      halt_set = 1;
      wt(1);
      halt_set = 0;
      chk(halted, 1, "halt taken");
      p = timing.timing_phase;
      wt(300);
      chk(timing.timing_phase, p, "halt freeze");
      halt_clear = 1;
      wt(1);
      halt_clear = 0;
      chk(halted, 0, "halt released");
      nextp;
      chk(timing.timing_phase, 3'(p + 3'h1), "resume");
      $display("t_halt done");
   endtask
   task t_flags;
      int n;
      n = 0;
      start_operation = 1;
      start_is_read_in = 1;
      wt(1);
      chk(nonload_operation_flag, 0, "read-in start");
      start_is_read_in = 0;
      wt(1);
      start_operation = 0;
      chk(nonload_operation_flag, 1, "nonload start");
      repeat_start = 1;
      wt(1);
      repeat_start = 0;
      chk(repeat_count_index, 5, "index load");
      chk(repeat_active_flag, 1, "repeat active");
      for (int i = 0; i < 800; i++) begin
         wt(1);
         n += new_instruction;
      end
      chk(n, 0, "no fetch in repeat");
      chk(repeat_count_index, 4, "index decrement");
      repeat_stop = 1;
      wt(1);
      repeat_stop = 0;
      chk(repeat_active_flag, 0, "repeat stopped");
      for (int i = 0; i < 800; i++) begin
         wt(1);
         n += new_instruction;
      end
      chk(n, 1, "one fetch per cycle");
      $display("t_flags done");
   endtask
   // Main sequence
   initial begin
      wt(4);
      sys_rst = 0;
      t_cycle;
      t_exit_hold;
      t_halt;
      t_flags;
      summarize;
   end
endmodule
